// file: hw/tpoc_top.sv
// timing pattern output controller with ahb-lite register slave
`timescale 1ns/100ps
`default_nettype none
module tpoc_top #(
	parameter int unsigned GAP_W = 8
) (
	input  wire logic                     clk,
	input  wire logic                     rst_b,
	input  wire tpoc_pkg::tpoc_ahb_req_t  ahb_req,
	output tpoc_pkg::tpoc_ahb_rsp_t       ahb_rsp,
	input  wire logic [3:0]               cmp_match,
	output logic [3:0]                    dma_req,
	output logic [15:0]                   pattern_output_pins,
	output logic [15:0]                   pattern_output_oe
);
	import tpoc_pkg::*;

	// ----------------------------------------
	// elaboration check
	// ----------------------------------------
	if (GAP_W < 1 || GAP_W > 8) begin : g_bad_gap
		$error("GAP_W must be 1 to 8");
	end

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic        wact;
		logic        rph;
		tpoc_sel_t   sel;
		logic [15:0] pdat;
		logic [15:0] fsh;
		logic [15:0] fsl;
		logic [3:0]  mode;
		logic [7:0]  trig;
		logic [7:0]  enu;
		logic [7:0]  enl;
		logic [7:0]  nxu;
		logic [7:0]  nxl;
		logic [7:0]  gap;
		logic [31:0] hrdata;
		logic        hready;
		logic [3:0]  dma;
		logic [15:0] oe;
	} tpoc_state_t;

	tpoc_state_t s;
	tpoc_state_t n;

	tpoc_sel_t   dsel;
	logic        same01;
	logic        same23;
	logic [15:0] en_all;
	logic [15:0] nx_all;
	logic [15:0] ld_mask;
	logic [15:0] ld_val;
	logic [3:0]  fire;
	logic [7:0]  rd;
	logic [15:0] rd16;
	logic        is16;
	logic [7:0]  wb;
	logic [15:0] wh;
	logic        take;

	// ----------------------------------------
	// decode and group wiring
	// ----------------------------------------
	tpoc_addr_dec u_dec (
		.haddr (ahb_req.haddr),
		.sel   (dsel)
	);

	// trigger fields: group g uses trig[2g+1:2g]
	assign same01 = s.trig[1:0] == s.trig[3:2];
	assign same23 = s.trig[5:4] == s.trig[7:6];
	assign en_all = {s.enu, s.enl};
	assign nx_all = {s.nxu, s.nxl};

	genvar g;
	generate
		for (g = 0; g < N_GRP; g++) begin : g_grp
			tpoc_group #(
				.GAP_W (GAP_W)
			) u_grp (
				.clk     (clk),
				.rst_b   (rst_b),
				.cmp     (cmp_match),
				.tsel    (s.trig[TSEL_W*g +: TSEL_W]),
				.en      (en_all[GRP_W*g +: GRP_W]),
				.nxt     (nx_all[GRP_W*g +: GRP_W]),
				.cur     (s.pdat[GRP_W*g +: GRP_W]),
				.nov     (s.mode[g]),
				.gap     (s.gap[GAP_W-1:0]),
				.fire    (fire[g]),
				.ld_mask (ld_mask[GRP_W*g +: GRP_W]),
				.ld_val  (ld_val[GRP_W*g +: GRP_W])
			);
		end
	endgenerate

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	always_comb begin
		rd   = '0;
		rd16 = '0;
		is16 = 1'b0;
		unique case (s.sel)
			SEL_PDAT: begin
				is16 = 1'b1;
				rd16 = s.pdat;
			end
			SEL_FSH: begin
				is16 = 1'b1;
				rd16 = s.fsh;
			end
			SEL_FSL: begin
				is16 = 1'b1;
				rd16 = s.fsl;
			end
			SEL_MODE: rd = {RSV_ONES, s.mode};
			SEL_TRIG: rd = s.trig;
			SEL_ENU:  rd = s.enu;
			SEL_ENL:  rd = s.enl;
			SEL_NXL: begin
				if (same01) begin
					rd = s.nxl;
				end else begin
					rd = {s.nxl[7:4], RSV_ONES};
				end
			end
			SEL_NXL2: begin
				if (same01) begin
					rd = {RSV_ONES, RSV_ONES};
				end else begin
					rd = {RSV_ONES, s.nxl[3:0]};
				end
			end
			SEL_NXU: begin
				if (same23) begin
					rd = s.nxu;
				end else begin
					rd = {s.nxu[7:4], RSV_ONES};
				end
			end
			SEL_NXU2: begin
				if (same23) begin
					rd = {RSV_ONES, RSV_ONES};
				end else begin
					rd = {RSV_ONES, s.nxu[3:0]};
				end
			end
			SEL_GAP:  rd = s.gap;
			SEL_NONE: rd = '0;
		endcase
	end

	assign wb   = ahb_req.hwdata[7:0];
	assign wh   = ahb_req.hwdata[15:0];
	assign take = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		n      = s;
		n.dma  = '0;
		n.wact = 1'b0;

		// read data phase: one wait state, data from flop
		if (s.rph) begin
			n.rph    = 1'b0;
			n.hready = 1'b1;
			n.hrdata = is16 ? {16'h0000, rd16} : {24'h000000, rd};
		end

		// write data phase
		if (s.wact) begin
			unique case (s.sel)
				SEL_PDAT: n.pdat = (s.pdat & en_all) | (wh & ~en_all);
				SEL_FSH:  n.fsh  = wh;
				SEL_FSL:  n.fsl  = wh;
				SEL_MODE: n.mode = wb[3:0];
				SEL_TRIG: n.trig = wb;
				SEL_ENU:  n.enu  = wb;
				SEL_ENL:  n.enl  = wb;
				SEL_NXL: begin
					if (same01) begin
						n.nxl = wb;
					end else begin
						n.nxl[7:4] = wb[7:4];
					end
				end
				SEL_NXL2: begin
					if (!same01) begin
						n.nxl[3:0] = wb[3:0];
					end
				end
				SEL_NXU: begin
					if (same23) begin
						n.nxu = wb;
					end else begin
						n.nxu[7:4] = wb[7:4];
					end
				end
				SEL_NXU2: begin
					if (!same23) begin
						n.nxu[3:0] = wb[3:0];
					end
				end
				SEL_GAP:  n.gap = wb;
				SEL_NONE: n.gap = s.gap;
			endcase
		end

		// trigger transfers follow software writes
		n.pdat = (n.pdat & ~ld_mask) | (ld_val & ld_mask);

		// address phase
		if (take) begin
			n.sel = dsel;
			if (ahb_req.hwrite) begin
				n.wact = 1'b1;
			end else begin
				n.rph    = 1'b1;
				n.hready = 1'b0;
			end
		end

		// dma request for each channel that fired a group
		for (int c = 0; c < N_CH; c++) begin
			for (int k = 0; k < N_GRP; k++) begin
				if (fire[k] && s.trig[TSEL_W*k +: TSEL_W] == TSEL_W'(c)) begin
					n.dma[c] = 1'b1;
				end
			end
		end

		// pin drive follows port function select
		for (int p = 0; p < 8; p++) begin
			n.oe[p]     = s.fsl[2*p +: 2] == FS_PATTERN;
			n.oe[p + 8] = s.fsh[2*p +: 2] == FS_PATTERN;
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s        <= '0;
			s.sel    <= SEL_NONE;
			s.pdat   <= RST_PDAT;
			s.fsh    <= RST_FS;
			s.fsl    <= RST_FS;
			s.mode   <= RST_MODE[3:0];
			s.trig   <= RST_TRIG;
			s.enu    <= RST_EN;
			s.enl    <= RST_EN;
			s.nxu    <= RST_NX;
			s.nxl    <= RST_NX;
			s.gap    <= RST_GAP;
			s.hready <= 1'b1;
		end else begin
			s <= n;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign ahb_rsp.hreadyout   = s.hready;
	assign ahb_rsp.hresp       = 1'b0;
	assign ahb_rsp.hrdata      = s.hrdata;
	assign dma_req             = s.dma;
	assign pattern_output_pins = s.pdat;
	assign pattern_output_oe   = s.oe;

endmodule
`default_nettype wire

// file: hw/tpoc_pkg.sv
// package: register map, field layout and bus types of the pattern output block
package tpoc_pkg;

	// ----------------------------------------
	// register indexes (byte address = 4 * index)
	// ----------------------------------------
	localparam logic [27:0] IX_PDAT = 28'h5ffffc2;
	localparam logic [27:0] IX_FSH  = 28'h5ffffcc;
	localparam logic [27:0] IX_FSL  = 28'h5ffffce;
	localparam logic [27:0] IX_MODE = 28'h5fffff0;
	localparam logic [27:0] IX_TRIG = 28'h5fffff1;
	localparam logic [27:0] IX_ENU  = 28'h5fffff2;
	localparam logic [27:0] IX_ENL  = 28'h5fffff3;
	localparam logic [27:0] IX_NXU  = 28'h5fffff4;
	localparam logic [27:0] IX_NXL  = 28'h5fffff5;
	localparam logic [27:0] IX_NXU2 = 28'h5fffff6;
	localparam logic [27:0] IX_NXL2 = 28'h5fffff7;
	localparam logic [27:0] IX_GAP  = 28'h5fffff8;

	// ----------------------------------------
	// reset values and fields
	// ----------------------------------------
	localparam logic [15:0] RST_PDAT = 16'h0000;
	localparam logic [15:0] RST_FS   = 16'h0000;
	localparam logic [7:0]  RST_MODE = 8'hf0;
	localparam logic [7:0]  RST_TRIG = 8'hff;
	localparam logic [7:0]  RST_EN   = 8'h00;
	localparam logic [7:0]  RST_NX   = 8'h00;
	localparam logic [7:0]  RST_GAP  = 8'h00;
	localparam logic [3:0]  RSV_ONES = 4'hf;
	localparam logic [1:0]  FS_PATTERN = 2'h3;
	localparam int unsigned GRP_W  = 4;
	localparam int unsigned N_GRP  = 4;
	localparam int unsigned N_CH   = 4;
	localparam int unsigned TSEL_W = 2;

	// ----------------------------------------
	// decoded register select
	// ----------------------------------------
	typedef enum logic [3:0] {
		SEL_NONE, SEL_PDAT, SEL_FSH, SEL_FSL, SEL_MODE, SEL_TRIG,
		SEL_ENU, SEL_ENL, SEL_NXU, SEL_NXL, SEL_NXU2, SEL_NXL2, SEL_GAP
	} tpoc_sel_t;

	// ----------------------------------------
	// ahb-lite carriers
	// ----------------------------------------
	typedef struct packed {
		logic        hsel;
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic [31:0] hwdata;
		logic        hready;
	} tpoc_ahb_req_t;

	typedef struct packed {
		logic        hreadyout;
		logic        hresp;
		logic [31:0] hrdata;
	} tpoc_ahb_rsp_t;

	// only index bits 27-24 and 8-0 take part in decode
	function automatic logic [12:0] tpoc_key(input logic [27:0] ix);
		return {ix[27:24], ix[8:0]};
	endfunction

endpackage

// file: hw/tpoc_addr_dec.sv
// address decoder of the pattern output register window
`timescale 1ns/100ps
`default_nettype none
module tpoc_addr_dec (
	input  wire logic [31:0]         haddr,
	output tpoc_pkg::tpoc_sel_t      sel
);
	import tpoc_pkg::*;

	logic [12:0] key;

	assign key = tpoc_key(haddr[29:2]);

	always_comb begin
		unique case (key)
			tpoc_key(IX_PDAT): sel = SEL_PDAT;
			tpoc_key(IX_FSH):  sel = SEL_FSH;
			tpoc_key(IX_FSL):  sel = SEL_FSL;
			tpoc_key(IX_MODE): sel = SEL_MODE;
			tpoc_key(IX_TRIG): sel = SEL_TRIG;
			tpoc_key(IX_ENU):  sel = SEL_ENU;
			tpoc_key(IX_ENL):  sel = SEL_ENL;
			tpoc_key(IX_NXU):  sel = SEL_NXU;
			tpoc_key(IX_NXL):  sel = SEL_NXL;
			tpoc_key(IX_NXU2): sel = SEL_NXU2;
			tpoc_key(IX_NXL2): sel = SEL_NXL2;
			tpoc_key(IX_GAP):  sel = SEL_GAP;
			default:           sel = SEL_NONE;
		endcase
	end

endmodule
`default_nettype wire

// file: hw/tpoc_group.sv
// one four-bit output group: trigger select and non-overlap delay
`timescale 1ns/100ps
`default_nettype none
module tpoc_group #(
	parameter int unsigned GAP_W = 8
) (
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic [3:0]       cmp,
	input  wire logic [1:0]       tsel,
	input  wire logic [3:0]       en,
	input  wire logic [3:0]       nxt,
	input  wire logic [3:0]       cur,
	input  wire logic             nov,
	input  wire logic [GAP_W-1:0] gap,
	output logic                  fire,
	output logic [3:0]            ld_mask,
	output logic [3:0]            ld_val
);
	import tpoc_pkg::*;

	typedef struct packed {
		logic [3:0]       pmask;
		logic [3:0]       pval;
		logic [GAP_W-1:0] cnt;
	} tpoc_grp_t;

	tpoc_grp_t  s;
	tpoc_grp_t  n;
	logic [3:0] rise;
	logic       due;

	assign fire = cmp[tsel] & (|en);
	assign rise = en & nxt & ~cur;
	assign due  = (s.cnt == '0) && (s.pmask != '0);

	always_comb begin
		n       = s;
		ld_mask = '0;
		ld_val  = '0;
		if (s.cnt != '0) begin
			n.cnt = s.cnt - 1'b1;
		end
		if (due) begin
			ld_mask = s.pmask;
			ld_val  = s.pval;
			n.pmask = '0;
		end
		if (fire) begin
			// rising bits wait out the gap; falling bits go at once
			if (nov) begin
				ld_mask = ld_mask | (en & ~rise);
				n.pmask = rise;
				n.pval  = nxt;
				n.cnt   = gap;
			end else begin
				ld_mask = ld_mask | en;
				n.pmask = s.pmask & ~en & ~ld_mask;
			end
			ld_val = (ld_val & ~en) | (nxt & en);
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

endmodule
`default_nettype wire

// file: tb/tpoc_properties.sv
// assertions on bus timing and trigger response of the pattern output block
`timescale 1ns/100ps
`default_nettype none
module tpoc_properties #(
	parameter int unsigned GAP_W = 8
) (
	input wire logic                    clk,
	input wire logic                    rst_b,
	input wire tpoc_pkg::tpoc_ahb_req_t ahb_req,
	input wire tpoc_pkg::tpoc_ahb_rsp_t ahb_rsp,
	input wire logic [3:0]              cmp_match,
	input wire logic [3:0]              dma_req,
	input wire logic [15:0]             pattern_output_pins,
	input wire logic [15:0]             pattern_output_oe
);
	import tpoc_pkg::*;
	wire tk = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready;
	wire wr = tk & ahb_req.hwrite;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	sequence s_rd;
		tk && !ahb_req.hwrite;
	endsequence
	sequence s_wait;
		!ahb_rsp.hreadyout ##1 ahb_rsp.hreadyout;
	endsequence
	a_resp_okay: assert property (ahb_rsp.hresp == 1'b0) else $error("hresp not okay");
	a_read_wait: assert property (s_rd |=> s_wait) else $error("read wait wrong");
	a_write_fast: assert property (wr |=> ahb_rsp.hreadyout) else $error("write stalled");
	a_wait_cause: assert property (!ahb_rsp.hreadyout |-> $past(tk) && !$past(ahb_req.hwrite)) else $error("stray wait");
	a_rdata_hold: assert property ($changed(ahb_rsp.hrdata) |-> $rose(ahb_rsp.hreadyout)) else $error("hrdata moved");
	a_rdata_upper: assert property (ahb_rsp.hrdata[31:16] == 16'h0) else $error("hrdata upper set");
	a_dma_cause: assert property ((dma_req & ~$past(cmp_match)) == 4'h0) else $error("dma without match");
	a_oe_write: assert property ($changed(pattern_output_oe) |-> $past(wr, 2) || $past(wr, 3)) else $error("oe moved");
endmodule
bind tpoc_top tpoc_properties #(.GAP_W(GAP_W)) u_tpoc_properties (
	.clk, .rst_b, .ahb_req, .ahb_rsp, .cmp_match, .dma_req, .pattern_output_pins, .pattern_output_oe
);
`default_nettype wire

// file: tb/tpoc_timer_model.sv
// timer stand-in: arms compare matches and pulses them once after a delay
`timescale 1ns/100ps
`default_nettype none
module tpoc_timer_model (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic [3:0] arm,
	input  wire logic [7:0] dly,
	output logic [3:0]      cmp_match
);
	logic [3:0] pend_q;
	logic [7:0] cnt_q;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pend_q <= '0;
			cnt_q <= '0;
			cmp_match <= '0;
		end else begin
			cmp_match <= '0;
			if (arm != 4'h0) begin
				pend_q <= arm;
				cnt_q <= dly;
			end else if (cnt_q != 8'h0) begin
				cnt_q <= cnt_q - 8'h1;
			end else begin
				cmp_match <= pend_q;
				pend_q <= '0;
			end
		end
	end
endmodule
`default_nettype wire

// file: tb/tpoc_top_test.sv
// testbench of the pattern output block
`timescale 1ns/100ps
`default_nettype none
module tpoc_top_test;
	import tpoc_pkg::*;
	logic          clk = 1'b0;
	logic          rst_b = 1'b0;
	tpoc_ahb_req_t m = '0;
	tpoc_ahb_req_t req;
	tpoc_ahb_rsp_t rsp;
	logic [3:0]    arm = '0;
	logic [7:0]    dly = '0;
	logic [3:0]    cmp_match;
	logic [3:0]    dma_req;
	logic [15:0]   pins;
	logic [15:0]   oe;
	logic [31:0]   rdv;
	logic [15:0]   pd, pf, en, nx;
	logic [7:0]    ts, sd;
	logic [3:0]    nv;
	int            miscompares = 0;
	int            n_compared = 0;
	logic [27:0]   rix [14] = '{IX_PDAT, IX_FSH, IX_FSL, IX_MODE, IX_TRIG, IX_ENU, IX_ENL,
		IX_NXU, IX_NXL, IX_NXU2, IX_NXL2, IX_GAP, 28'h50001f1, 28'h5ffff00};
	logic [7:0]    rex [14] = '{8'h00, 8'h00, 8'h00, 8'hf0, 8'hff, 8'h00, 8'h00,
		8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'hff, 8'h00};

	always #50 clk = ~clk;
	always_comb begin
		req = m;
		req.hready = rsp.hreadyout;
	end

	tpoc_top u_tpoc_top (.clk, .rst_b, .ahb_req(req), .ahb_rsp(rsp), .cmp_match, .dma_req,
		.pattern_output_pins(pins), .pattern_output_oe(oe));
	tpoc_timer_model u_tpoc_timer_model (.clk, .rst_b, .arm, .dly, .cmp_match);

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			miscompares++;
			$display("BAD %0t seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic bus(input logic [27:0] ix, input logic w, input logic [31:0] d);
		m.hsel <= 1'b1;
		m.haddr <= {2'b00, ix, 2'b00};
		m.htrans <= 2'h2;
		m.hwrite <= w;
		m.hsize <= 3'h2;
		do @(posedge clk); while (rsp.hreadyout !== 1'b1);
		m.htrans <= 2'h0;
		m.hwdata <= d;
		do @(posedge clk); while (rsp.hreadyout !== 1'b1);
		rdv = rsp.hrdata;
	endtask

	task automatic rd(input logic [27:0] ix, input logic [31:0] e);
		bus(ix, 1'b0, 32'h0);
		chk(rdv, e);
	endtask

	task automatic fire(input int ch, input logic [7:0] d);
		logic [3:0] ed;
		logic [3:0] k;
		ed = '0;
		pf = pd;
		arm <= 4'h1 << ch;
		dly <= d;
		@(posedge clk);
		arm <= 4'h0;
		for (int g = 0; g < 4; g++) begin
			k = en[4*g+:4];
			if (ts[2*g+:2] == ch[1:0] && k != 4'h0) begin
				ed[ch] = 1'b1;
				pf[4*g+:4] = pd[4*g+:4] & ~k | nx[4*g+:4] & k;
				pd[4*g+:4] = nv[g] ? pd[4*g+:4] & (~k | nx[4*g+:4]) : pf[4*g+:4];
			end
		end
		while (cmp_match !== 4'h1 << ch) @(posedge clk);
		@(posedge clk);
		chk(dma_req, ed);
		chk(pins, pd);
	endtask

	task automatic print_verdict;
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge clk);
		miscompares++;
		print_verdict();
	end

	initial begin
		sd = 8'h5d;
		{pd, pf, en, nx, nv} = '0;
		ts = 8'hff;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		chk({pins, oe}, 32'h0);
		foreach (rix[i]) rd(rix[i], {24'h0, rex[i]});
		$display("test reset done");
		sd = lfsr(sd);
		bus(IX_FSH, 1'b1, {16'h0, sd, 8'hff});
		bus(IX_FSL, 1'b1, {16'h0, 8'hc3, sd});
		// select lands at the end of the data phase, pin drive one edge after that
		repeat (2) @(posedge clk);
		for (int i = 0; i < 16; i++) chk(oe[i], &(2'({sd, 8'hff, 8'hc3, sd} >> (2 * i))));
		sd = lfsr(sd);
		nx = {~sd, sd};
		bus(IX_NXL, 1'b1, {24'h0, sd});
		bus(IX_NXU, 1'b1, {24'h0, ~sd});
		bus(IX_NXL2, 1'b1, 32'h0);
		bus(28'h5ffff00, 1'b1, 32'hff);
		rd(IX_NXL2, 32'hff);
		rd(28'h5ffff00, 32'h0);
		rd(IX_NXL, {24'h0, sd});
		bus(IX_ENU, 1'b1, 32'hff);
		bus(IX_ENL, 1'b1, 32'hff);
		en = 16'hffff;
		fire(3, 8'h0);
		bus(IX_PDAT, 1'b1, 32'h0);
		rd(IX_PDAT, {16'h0, pd});
		$display("test shared done");
		ts = 8'h94;
		bus(IX_TRIG, 1'b1, 32'h94);
		en = 16'h0ff0;
		bus(IX_ENU, 1'b1, 32'h0f);
		bus(IX_ENL, 1'b1, 32'hf0);
		sd = lfsr(sd);
		bus(IX_PDAT, 1'b1, {16'h0, sd, ~sd});
		pd = pd & en | {sd, ~sd} & ~en;
		rd(IX_PDAT, {16'h0, pd});
		sd = lfsr(sd);
		nx = {sd, ~sd};
		bus(IX_NXL, 1'b1, {24'h0, nx[7:4], 4'h0});
		bus(IX_NXL2, 1'b1, {24'h0, 4'h0, nx[3:0]});
		bus(IX_NXU, 1'b1, {24'h0, nx[15:12], 4'h0});
		bus(IX_NXU2, 1'b1, {24'h0, 4'h0, nx[11:8]});
		rd(IX_NXL, {24'h0, nx[7:4], 4'hf});
		rd(IX_NXL2, {24'h0, 4'hf, nx[3:0]});
		rd(IX_NXU, {24'h0, nx[15:12], 4'hf});
		rd(IX_NXU2, {24'h0, 4'hf, nx[11:8]});
		fire(0, 8'h3);
		fire(1, 8'h0);
		fire(2, 8'h1);
		$display("test split done");
		nv = 4'h2;
		bus(IX_MODE, 1'b1, 32'h02);
		rd(IX_MODE, 32'hf2);
		bus(IX_GAP, 1'b1, 32'h2);
		nx[7:4] = ~pd[7:4];
		bus(IX_NXL, 1'b1, {24'h0, nx[7:4], 4'h0});
		fire(1, 8'h2);
		repeat (2) @(posedge clk);
		chk(pins, pd);
		@(posedge clk);
		chk(pins, pf);
		$display("test gap done");
		print_verdict();
	end
endmodule
`default_nettype wire
